// ### common/vhid_defines.vh
// constants for the vga host interface decode block
`ifndef VHID_DEFINES_VH
`define VHID_DEFINES_VH
`define VHID_ROM_BASE        20'h0_C000
`define VHID_ROM_LAST        20'h0_C7FF
`define VHID_ROM_SHIFT       4
`define VHID_PAL_FIRST       16'h03C6
`define VHID_PAL_LAST        16'h03C9
`define VHID_SEQ_IDX         16'h03C4
`define VHID_GFX_IDX         16'h03CE
`define VHID_CRT_MONO        16'h03B4
`define VHID_CRT_COLR        16'h03D4
`define VHID_ATR_IDX         16'h03C0
`define VHID_VRAM_BASE       20'hA_0000
`define VHID_VRAM_LAST       20'hB_FFFF
`define VHID_EXT_IDX         16'h03D6
`define VHID_EXT_DAT         16'h03D7
`define VHID_EXT_LATCH0      8'h00
`define VHID_EXT_ATRFF       8'h04
`define VHID_EXT_CTRL        8'h0A
`define VHID_EXT_MCTL        8'h0B
`define VHID_MEM_WAITS       4'h3
`define VHID_DOT_DIV         2'h1
`endif

// ### core/vhid_top.v
// vga host interface decode: rom select, palette strobes, display memory access, extension gating
`timescale 1ns/1ps
`default_nettype none
`include "vhid_defines.vh"
// What this block does
// - pc bus strap: rom range asserts rom select
// - adapter bus strap: never assert rom select
// - all 256k memory reachable in plane modes 0, 1 and 3; mode 2 reaches only 128k
// - memory strobes timed from dot clock
// - 16-bit memory cycles sequenced from memory clock
// - reset disables all extended functions
// - extended writes need both enable sets set
// - extended reads return latches and attribute toggle
// - standard registers gain no new bits
// - palette io range drives external read/write strobes
// - reset gives 8-bit memory and io
// - 16-bit io only on index/data pairs
// - cycle width from lowest address bit, high byte enable
// - io and rom reads without waits, display memory stretched with waits
module vhid_top (
    input  wire        REF_CLK_I,
    input  wire        RST_N_I,
    input  wire        CLK_EN_I,
    input  wire        BUS_STRAP_ADAPTER_I,
    input  wire        MEM_CLK_TICK_I,
    input  wire        DOT_CLK_TICK_I,
    input  wire [19:0] ADDR_I,
    input  wire        HIGH_BYTE_ENABLE_N_I,
    input  wire        MEM_RD_I,
    input  wire        MEM_WR_I,
    input  wire        IO_RD_I,
    input  wire        IO_WR_I,
    input  wire [15:0] DATA_I,
    input  wire [1:0]  PLANE_MODE_I,
    input  wire [1:0]  WRITE_PLANE_I,
    input  wire [31:0] GFX_LATCH_I,
    input  wire        ATTR_TOGGLE_I,
    input  wire        EXT_KEY_A_I,
    input  wire        EXT_KEY_B_I,
    output reg         VIDEO_ROM_SELECT_N_O,
    output reg         PAL_RD_N_O,
    output reg         PAL_WR_N_O,
    output reg         IO_CYCLE_16_O,
    output reg         MEM_CYCLE_16_O,
    output reg         BUS_READY_O,
    output reg  [17:0] VRAM_ADDR_O,
    output reg  [3:0]  VRAM_PLANE_EN_O,
    output reg         VRAM_RAS_N_O,
    output reg         VRAM_CAS_N_O,
    output reg         VRAM_WE_N_O,
    output reg  [7:0]  EXT_RD_DATA_O,
    output reg         EXT_RD_VALID_O,
    output reg  [7:0]  EXT_CTRL_O,
    output reg         EXT_ACTIVE_O
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_RAS  = 4'b0010;
    localparam ST_CAS  = 4'b0100;
    localparam ST_DONE = 4'b1000;

    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [3:0]  wait_q;
    reg  [7:0]  ext_idx_q;
    reg  [7:0]  ext_mctl_q;
    reg         served_q;
    wire [15:0] io_addr = ADDR_I[15:0];

    function is_pair;
        input [15:0] a;
        begin
            is_pair = (a == `VHID_SEQ_IDX) || (a == `VHID_GFX_IDX) ||
                      (a == `VHID_CRT_MONO) || (a == `VHID_CRT_COLR) || (a == `VHID_ATR_IDX);
        end
    endfunction

    function in_window;
        input [19:0] a;
        input [19:0] lo;
        input [19:0] hi;
        begin
            in_window = (a >= lo) && (a <= hi);
        end
    endfunction

    function [3:0] plane_onehot;
        input [1:0] sel;
        begin
            case (sel)
                2'b00:   plane_onehot = 4'h1;
                2'b01:   plane_onehot = 4'h2;
                2'b10:   plane_onehot = 4'h4;
                default: plane_onehot = 4'h8;
            endcase
        end
    endfunction

    // unknown indices read as zero so software probing the space sees nothing new
    function [7:0] ext_readback;
        input [7:0]  idx;
        input [31:0] latch;
        input        toggle;
        input [7:0]  ctrl;
        input [7:0]  mctl;
        begin
            case (idx)
                `VHID_EXT_LATCH0: ext_readback = latch[7:0];
                8'h01:            ext_readback = latch[15:8];
                8'h02:            ext_readback = latch[23:16];
                8'h03:            ext_readback = latch[31:24];
                `VHID_EXT_ATRFF:  ext_readback = {7'h00, toggle};
                `VHID_EXT_CTRL:   ext_readback = ctrl;
                `VHID_EXT_MCTL:   ext_readback = mctl;
                default:          ext_readback = 8'h00;
            endcase
        end
    endfunction

    wire in_rom  = in_window(ADDR_I, `VHID_ROM_BASE << `VHID_ROM_SHIFT,
                             (`VHID_ROM_LAST << `VHID_ROM_SHIFT) | 20'h0_000F);
    wire in_pal  = in_window({4'h0, io_addr}, {4'h0, `VHID_PAL_FIRST}, {4'h0, `VHID_PAL_LAST});
    wire in_vram = in_window(ADDR_I, `VHID_VRAM_BASE, `VHID_VRAM_LAST);
    // both key sets must be held; keys are reset by the host-side register owner
    wire ext_open = EXT_KEY_A_I && EXT_KEY_B_I;
    wire ext_wr  = IO_WR_I && (io_addr == `VHID_EXT_DAT) && ext_open;
    wire ext_rd  = IO_RD_I && (io_addr == `VHID_EXT_DAT);
    wire mem_req = (MEM_RD_I || MEM_WR_I) && in_vram;
    // requests are levels that outlive their cycle; served_q stops a second start
    wire mem_new = mem_req && !served_q;
    wire wide    = !ADDR_I[0] && !HIGH_BYTE_ENABLE_N_I;

    // chain modes fold plane select into low address bits; in mode 2 ADDR_I[17] is always set in the window, so half the offsets are unreachable
    reg  [17:0] map_addr;
    reg  [3:0]  map_plane;
    always @* begin
        map_addr  = {2'b00, ADDR_I[15:0]};
        map_plane = 4'h0;
        case (PLANE_MODE_I)
            2'b00: begin
                map_addr  = {2'b00, ADDR_I[15:0]};
                map_plane = 4'hF;
            end
            2'b01: begin
                map_addr  = {2'b00, ADDR_I[16:1]};
                map_plane = ADDR_I[0] ? 4'hA : 4'h5;
            end
            2'b10: begin
                map_addr  = {2'b00, ADDR_I[17:2]};
                map_plane = plane_onehot(ADDR_I[1:0]);
            end
            default: begin
                map_addr  = {ADDR_I[15:0], WRITE_PLANE_I};
                map_plane = plane_onehot(WRITE_PLANE_I);
            end
        endcase
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (mem_new) state_d = ST_RAS;
            ST_RAS:  if (DOT_CLK_TICK_I) state_d = ST_CAS;
            ST_CAS:  if (wait_q == `VHID_MEM_WAITS && MEM_CLK_TICK_I) state_d = ST_DONE;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // decode strobes follow the request level one cycle late
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            VIDEO_ROM_SELECT_N_O <= 1'b1;
            PAL_RD_N_O           <= 1'b1;
            PAL_WR_N_O           <= 1'b1;
            IO_CYCLE_16_O        <= 1'b0;
            MEM_CYCLE_16_O       <= 1'b0;
            BUS_READY_O          <= 1'b1;
        end else if (CLK_EN_I) begin
            VIDEO_ROM_SELECT_N_O <= !(MEM_RD_I && in_rom && !BUS_STRAP_ADAPTER_I);
            PAL_RD_N_O           <= !(IO_RD_I && in_pal);
            PAL_WR_N_O           <= !(IO_WR_I && in_pal);
            IO_CYCLE_16_O  <= ext_mctl_q[1] && wide && is_pair(io_addr) && (IO_RD_I || IO_WR_I);
            MEM_CYCLE_16_O <= ext_mctl_q[0] && wide && mem_req;
            // io never waits; display memory holds ready low until done, rom reads never wait
            BUS_READY_O <= !(mem_new && state_q != ST_DONE);
        end
    end

    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            ext_idx_q    <= 8'h00;
            ext_mctl_q   <= 8'h00;
            EXT_CTRL_O   <= 8'h00;
            EXT_ACTIVE_O <= 1'b0;
        end else if (CLK_EN_I) begin
            // only extended index space accepts new control
            if (IO_WR_I && io_addr == `VHID_EXT_IDX && ext_open)
                ext_idx_q <= DATA_I[7:0];
            if (ext_wr && ext_idx_q == `VHID_EXT_CTRL)
                EXT_CTRL_O <= DATA_I[7:0];
            if (ext_wr && ext_idx_q == `VHID_EXT_MCTL)
                ext_mctl_q <= DATA_I[7:0];
            EXT_ACTIVE_O <= |EXT_CTRL_O;
        end
    end

    // read data is registered and announced by a valid that follows the read level one cycle late
    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            EXT_RD_DATA_O  <= 8'h00;
            EXT_RD_VALID_O <= 1'b0;
        end else if (CLK_EN_I) begin
            EXT_RD_VALID_O <= ext_rd;
            if (ext_rd)
                EXT_RD_DATA_O <= ext_readback(ext_idx_q, GFX_LATCH_I, ATTR_TOGGLE_I, EXT_CTRL_O, ext_mctl_q);
        end
    end

    always @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state_q         <= ST_IDLE;
            wait_q          <= 4'h0;
            served_q        <= 1'b0;
            VRAM_ADDR_O     <= 18'h0_0000;
            VRAM_PLANE_EN_O <= 4'h0;
            VRAM_RAS_N_O    <= 1'b1;
            VRAM_CAS_N_O    <= 1'b1;
            VRAM_WE_N_O     <= 1'b1;
        end else if (CLK_EN_I) begin
            state_q <= state_d;
            if (!mem_req)
                served_q <= 1'b0;
            else if (state_q == ST_DONE)
                served_q <= 1'b1;
            // ras/cas fall on dot ticks and rise in done, 16-bit sequencing counts memory clock ticks
            case (state_q)
                ST_IDLE: begin
                    wait_q <= 4'h0;
                    if (mem_new) begin
                        VRAM_ADDR_O     <= map_addr;
                        VRAM_PLANE_EN_O <= map_plane;
                        VRAM_WE_N_O     <= !MEM_WR_I;
                    end
                end
                ST_RAS: if (DOT_CLK_TICK_I) VRAM_RAS_N_O <= 1'b0;
                ST_CAS: begin
                    if (DOT_CLK_TICK_I) VRAM_CAS_N_O <= 1'b0;
                    if (MEM_CLK_TICK_I && wait_q != `VHID_MEM_WAITS) wait_q <= wait_q + 4'h1;
                end
                ST_DONE: begin
                    VRAM_RAS_N_O <= 1'b1;
                    VRAM_CAS_N_O <= 1'b1;
                    VRAM_WE_N_O  <= 1'b1;
                    VRAM_PLANE_EN_O <= 4'h0;
                end
                default: wait_q <= 4'h0;
            endcase
        end
    end
endmodule // vhid_top
`default_nettype wire

// ### bench/vhid_props.sv
// checker for the vga host interface decode ports
`timescale 1ns/1ps
`default_nettype none
`include "vhid_defines.vh"
module vhid_props (
    input wire logic        REF_CLK_I, RST_N_I, CLK_EN_I, BUS_STRAP_ADAPTER_I, HIGH_BYTE_ENABLE_N_I,
    input wire logic        MEM_RD_I, IO_RD_I, IO_WR_I, EXT_KEY_A_I, EXT_KEY_B_I,
    input wire logic [19:0] ADDR_I,
    input wire logic        VIDEO_ROM_SELECT_N_O, PAL_RD_N_O, PAL_WR_N_O, IO_CYCLE_16_O, MEM_CYCLE_16_O,
    input wire logic        BUS_READY_O, EXT_ACTIVE_O,
    input wire logic [7:0]  EXT_CTRL_O
);
    wire logic pal = ADDR_I[15:0] >= `VHID_PAL_FIRST && ADDR_I[15:0] <= `VHID_PAL_LAST;
    wire logic io = CLK_EN_I && (IO_RD_I || IO_WR_I);
    wire logic lock = !(EXT_KEY_A_I && EXT_KEY_B_I);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_rom_sel; CLK_EN_I && MEM_RD_I && !BUS_STRAP_ADAPTER_I && ADDR_I[19:15] == 5'h18 |=> !VIDEO_ROM_SELECT_N_O; endproperty
    a_rom_sel: assert property (p_rom_sel) else $error("rom select missing");
    property p_rom_adp; BUS_STRAP_ADAPTER_I && $past(BUS_STRAP_ADAPTER_I) |-> VIDEO_ROM_SELECT_N_O; endproperty
    a_rom_adp: assert property (p_rom_adp) else $error("rom select on adapter bus");
    property p_pal_on; CLK_EN_I && pal |=> PAL_RD_N_O == !$past(IO_RD_I) && PAL_WR_N_O == !$past(IO_WR_I); endproperty
    a_pal_on: assert property (p_pal_on) else $error("palette strobe wrong");
    property p_pal_off; CLK_EN_I && !pal |=> PAL_RD_N_O && PAL_WR_N_O; endproperty
    a_pal_off: assert property (p_pal_off) else $error("palette strobe outside range");
    property p_io_rdy; io && !MEM_RD_I |=> BUS_READY_O; endproperty
    a_io_rdy: assert property (p_io_rdy) else $error("io cycle waited");
    property p_mem_wait; CLK_EN_I && $rose(MEM_RD_I) && ADDR_I[19:17] == 3'h5 |=> !BUS_READY_O ##[1:300] BUS_READY_O; endproperty
    a_mem_wait: assert property (p_mem_wait) else $error("memory wait wrong");
    property p_io8; io && (ADDR_I[0] || HIGH_BYTE_ENABLE_N_I || pal) |=> !IO_CYCLE_16_O; endproperty
    a_io8: assert property (p_io8) else $error("16-bit io cycle not allowed");
    property p_rst; $rose(RST_N_I) |-> EXT_CTRL_O == 8'h00 && !EXT_ACTIVE_O && !IO_CYCLE_16_O && !MEM_CYCLE_16_O; endproperty
    a_rst: assert property (p_rst) else $error("state after reset wrong");
    property p_lock; lock && $past(lock) |=> $stable(EXT_CTRL_O); endproperty
    a_lock: assert property (p_lock) else $error("locked extension changed");
endmodule // vhid_props
bind vhid_top vhid_props props_u (.REF_CLK_I, .RST_N_I, .CLK_EN_I, .BUS_STRAP_ADAPTER_I, .HIGH_BYTE_ENABLE_N_I,
    .MEM_RD_I, .IO_RD_I, .IO_WR_I, .EXT_KEY_A_I, .EXT_KEY_B_I, .ADDR_I, .VIDEO_ROM_SELECT_N_O, .PAL_RD_N_O,
    .PAL_WR_N_O, .IO_CYCLE_16_O, .MEM_CYCLE_16_O, .BUS_READY_O, .EXT_ACTIVE_O, .EXT_CTRL_O);
`default_nettype wire

// ### bench/vhid_host_model.sv
// host processor model on the pc-style bus
`timescale 1ns/1ps
`default_nettype none
module vhid_host_model (
    input  wire logic        clk_i,
    input  wire logic        rdy_i,
    output var  logic [19:0] a_o,
    output var  logic [15:0] d_o,
    output var  logic [4:0]  ctl_o
);
    initial {a_o, d_o, ctl_o} = '0;
    // ctl_o: high byte enable low, mem rd, mem wr, io rd, io wr
    task automatic start(input logic [19:0] x, input logic [15:0] v, input logic m, input logic w);
        @(posedge clk_i);
        #1;
        a_o = x;
        d_o = v;
        ctl_o = {x[0], m && !w, m && w, !m && !w, !m && w};
        @(posedge clk_i);
        #1;
    endtask
    // released lines show the inverse so stale data never looks valid
    task automatic finish(input logic m);
        int n = 0;
        if (m) begin
            @(posedge clk_i);
            while (!rdy_i && n++ < 500) @(posedge clk_i);
            #1;
        end
        ctl_o = 5'h10;
        a_o = ~a_o;
        d_o = ~d_o;
    endtask
endmodule // vhid_host_model
`default_nettype wire

// ### bench/vhid_top_bench.sv
// self-checking bench for the vga host interface decode block
`timescale 1ns/1ps
`default_nettype none
module vhid_top_bench;
    logic clk = 0, rst_n = 0, strap = 0, mt = 0, dt = 0, ka = 0, kb = 0, at = 0;
    logic [1:0] pm = 0, wp = 0;
    logic [31:0] gl = 0;
    logic en = 1, frz = 0;
    logic [1:0] wid = 0;
    wire logic [7:0] rdd;
    wire logic rdv;
    wire logic [17:0] va;
    wire logic [19:0] a;
    wire logic [15:0] d;
    wire logic [4:0] c;
    wire logic rom_n, prd_n, pwr_n, io16, m16, rdy, act;
    wire logic [7:0] ctl;
    int failures = 0, n_checks = 0;
    vhid_host_model host_u (.clk_i(clk), .rdy_i(rdy), .a_o(a), .d_o(d), .ctl_o(c));
    vhid_top dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(en), .BUS_STRAP_ADAPTER_I(strap),
        .MEM_CLK_TICK_I(mt), .DOT_CLK_TICK_I(dt), .ADDR_I(a), .HIGH_BYTE_ENABLE_N_I(c[4]), .MEM_RD_I(c[3]),
        .MEM_WR_I(c[2]), .IO_RD_I(c[1]), .IO_WR_I(c[0]), .DATA_I(d), .PLANE_MODE_I(pm), .WRITE_PLANE_I(wp),
        .GFX_LATCH_I(gl), .ATTR_TOGGLE_I(at), .EXT_KEY_A_I(ka), .EXT_KEY_B_I(kb), .VIDEO_ROM_SELECT_N_O(rom_n),
        .PAL_RD_N_O(prd_n), .PAL_WR_N_O(pwr_n), .IO_CYCLE_16_O(io16), .MEM_CYCLE_16_O(m16), .BUS_READY_O(rdy),
        .VRAM_ADDR_O(va), .VRAM_PLANE_EN_O(), .VRAM_RAS_N_O(), .VRAM_CAS_N_O(), .VRAM_WE_N_O(),
        .EXT_RD_DATA_O(rdd), .EXT_RD_VALID_O(rdv), .EXT_CTRL_O(ctl), .EXT_ACTIVE_O(act));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        #1;
        {mt, dt, at} = 3'($urandom);
        if (!frz) begin
            {pm, wp} = 4'($urandom);
            gl = $urandom;
        end
    end
    task automatic chk(input logic ok);
        n_checks++;
        if (!ok) begin
            failures++;
            $display("ERROR at %0t: output mismatch", $time);
        end
    endtask
    function automatic logic pal(input logic [19:0] x);
        return x[15:0] >= 16'h03C6 && x[15:0] <= 16'h03C9;
    endfunction
    function automatic logic pair(input logic [19:0] x);
        return x[15:0] inside {16'h03C4, 16'h03CE, 16'h03B4, 16'h03D4, 16'h03C0};
    endfunction
    task automatic op(input logic [19:0] x, input logic m, input logic w, input logic [15:0] v);
        host_u.start(x, v, m, w);
        chk(rom_n === !(m && !strap && x >= 20'hC_0000 && x <= 20'hC_7FFF));
        chk(prd_n === !(!m && !w && pal(x)) && pwr_n === !(!m && w && pal(x)));
        chk(io16 === (wid[1] && !m && !x[0] && pair(x)) && (m || rdy === 1'b1));
        chk(m16 === (wid[0] && m && !x[0] && x >= 20'hA_0000 && x <= 20'hB_FFFF));
        host_u.finish(m);
        chk(!m || rdy === 1'b1);
    endtask
    task automatic final_report;
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200_000;
        failures++;
        final_report();
    end
    initial begin
        void'($urandom(98267));
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        for (int i = 0; i < 160; i++) begin
            strap = i >= 80;
            case ($urandom % 4)
                0: op(20'h003C5 + 20'($urandom % 6), 0, 1'($urandom), 16'($urandom));
                1: op(20'hC_0000 + 20'($urandom % 20'h1_0000), 1, 0, 0);
                2: op(20'hA_0000 + 20'($urandom % 20'h2_0000), 1, 0, 0);
                default: op(20'($urandom), 0, 1'($urandom), 16'($urandom));
            endcase
        end
        // only both enable sets together may unlock the extension writes
        for (int k = 0; k < 4; k++) begin
            {ka, kb} = 2'(k);
            op(20'h003D6, 0, 1, 16'h000A);
            op(20'h003D7, 0, 1, 16'h00A5);
            @(posedge clk);
            #1;
            chk(ctl === (k == 3 ? 8'hA5 : 8'h00));
        end
        // a low clock enable must freeze the extension registers
        en = 0;
        op(20'h003D7, 0, 1, 16'h005A);
        chk(ctl === 8'hA5);
        en = 1;
        frz = 1;
        gl = 32'h1234_5678;
        op(20'h003D6, 0, 1, 16'h0001);
        op(20'h003D7, 0, 0, 16'h0000);
        chk(rdv === 1'b1 && rdd === 8'h56);
        pm = 2'b00;
        op(20'hA_0123, 1, 0, 0);
        chk(va === 18'h0_0123);
        pm = 2'b01;
        op(20'hA_0247, 1, 0, 0);
        chk(va === 18'h0_0123);
        frz = 0;
        // switch both interfaces to 16 bits, then probe pairs, palette and memory
        op(20'h003D6, 0, 1, 16'h000B);
        op(20'h003D7, 0, 1, 16'h0003);
        wid = 2'b11;
        op(20'h003C4, 0, 1, 16'h1234);
        op(20'h003C8, 0, 1, 16'h0012);
        op(20'h003C5, 0, 1, 16'h0012);
        op(20'hA_0100, 1, 0, 0);
        rst_n = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        wid = 2'b00;
        chk(ctl === 8'h00 && act === 1'b0);
        op(20'h003C4, 0, 1, 16'h0000);
        final_report();
    end
endmodule // vhid_top_bench
`default_nettype wire
